/* rtl/sdcm_banks.sv */
module sdcm_banks (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        act_in,
  input  wire logic        pre_in,
  input  wire logic        pre_all_in,
  input  wire logic [1:0]  bank_in,
  input  wire logic [10:0] row_in,
  input  wire logic        ap_in,
  input  wire logic [1:0]  ap_bank_in,
  output logic      [3:0]  open_out,
  output logic      [3:0]  idle_out,
  output logic      [3:0]  row_lsb_out
);
  import sdcm_pkg::*;

  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      logic [2:0]  rec_cnt;
      logic [10:0] row;
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          open_out[b] <= 1'b0;
          rec_cnt     <= 3'h0;
          row         <= 11'h000;
        end else if (pre_all_in || (pre_in && bank_in == 2'(b)) ||
                     (ap_in && ap_bank_in == 2'(b))) begin
          open_out[b] <= 1'b0; // R16 R18
          rec_cnt     <= 3'(TRP_CYC); // R17
        end else if (act_in && bank_in == 2'(b) && idle_out[b]) begin
          open_out[b] <= 1'b1; // R10
          row         <= row_in;
        end else if (rec_cnt != 3'h0) begin
          rec_cnt <= rec_cnt - 3'h1;
        end
      end
      assign idle_out[b]    = !open_out[b] && rec_cnt == 3'h0; // R17
      assign row_lsb_out[b] = row[0];
    end
  endgenerate
endmodule

/* rtl/sdcm_core.sv */
// Contract
// R01: only mode bits 7 and 8 both zero give normal operation.
// R02: write single access select turns writes into one-location accesses.
// R03: controller picks a read latency the link clock rate allows.
// R04: selected commands decode from row, column and write strobe levels.
// R05: deselected device takes no command; running bursts continue.
// R06: no-op registers nothing and leaves running work alone.
// R07: refresh with clock enable high refreshes, low enters self refresh.
// R08: refresh row comes from internal counter; other inputs ignored.
// R09: load mode captures address 0..10 when all banks are idle.
// R10: activate opens given row in selected bank until precharged.
// R11: controller precharges before activating another row in a bank.
// R12: read/write use column bits 0..7, bank select, bit 10 auto precharge.
// R13: read byte mask high floats that byte two clocks later.
// R14: byte mask lane n governs data bits 8n to 8n+7.
// R15: write byte mask high with the data blocks that byte.
// R16: precharge closes one bank, or all banks when bit 10 high.
// R17: precharged bank is usable only after recovery time.
// R18: auto precharge closes bank at burst end, never for full page.
// R19: auto precharge choice is per command, never carried over.
// R20: controller waits recovery time after auto-precharged bursts.
// R21: controller never programs test or reserved modes; the testbench loads the three test modes on purpose to see them flagged.
// R22: mode fields: burst length 0..2, order bit 3, latency 4..6.
// R23: read at edge n drives after edge n+m-1, valid at n+m.
// R24: bursts wrap inside an aligned block of burst-length columns.
module sdcm_core (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        sd_clk_in,
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic        bank_select_0_in,
  input  wire logic        bank_select_1_in,
  input  wire logic [10:0] addr_in,
  input  wire logic        byte_mask_lane0_in,
  input  wire logic        byte_mask_lane1_in,
  input  wire logic        byte_mask_lane2_in,
  input  wire logic        byte_mask_lane3_in,
  input  wire logic [31:0] dq_in,
  output logic      [31:0] dq_out,
  output logic      [3:0]  dq_oe_out,
  output logic             self_refresh_out,
  output logic      [11:0] refresh_row_out,
  output logic      [3:0]  bank_open_out,
  output logic             test_mode_out
);
  import sdcm_pkg::*;

  sdcm_pins_s  pin_raw;
  sdcm_pins_s  pin_meta;
  sdcm_pins_s  pin;
  logic        clk_prev;
  logic        link_edge;
  sdcm_cmd_e   cmd;
  logic        take;
  logic [10:0] operation_mode_register;
  logic [2:0]  bl;
  logic        il;
  logic [1:0]  rl_eff;
  logic        normal;
  logic        wsingle;
  logic [3:0]  open;
  logic [3:0]  idle;
  logic [3:0]  row_lsb;
  logic        new_rd;
  logic        new_wr;
  logic        new_rw;
  logic        kill;
  sdcm_burst_e burst_st;
  logic [1:0]  lat_cnt;
  logic [7:0]  start_col;
  logic [7:0]  beat_idx;
  logic [8:0]  rem;
  logic [1:0]  burst_bank;
  logic        burst_ap;
  logic [2:0]  burst_bl;
  logic        burst_il;
  logic [7:0]  cur_start;
  logic [7:0]  cur_idx;
  logic [1:0]  cur_bank;
  logic [2:0]  cur_bl;
  logic        cur_il;
  logic        cur_ap;
  logic [8:0]  cur_rem;
  logic [7:0]  cur_col;
  logic        fire_rd;
  logic        fire_wr;
  logic        last;
  logic        ap_pre;
  logic [3:0]  dqm_prev;
  logic [31:0] rdata;
  logic        self_ref;
  logic [11:0] refresh_row;

  always_comb begin
    pin_raw.sd_clk = sd_clk_in;
    pin_raw.cke    = cke_in;
    pin_raw.cs_n   = cs_n_in;
    pin_raw.ras_n  = ras_n_in;
    pin_raw.cas_n  = cas_n_in;
    pin_raw.we_n   = we_n_in;
    pin_raw.ba     = {bank_select_1_in, bank_select_0_in};
    pin_raw.addr   = addr_in;
    pin_raw.dqm    = {byte_mask_lane3_in, byte_mask_lane2_in,
                      byte_mask_lane1_in, byte_mask_lane0_in};
    pin_raw.dq     = dq_in;
  end

  // every pin passes two flops; the link clock is found by its rise
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta <= PINS_IDLE;
      pin      <= PINS_IDLE;
      clk_prev <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin      <= pin_meta;
      clk_prev <= pin.sd_clk;
    end
  end

  assign link_edge = pin.sd_clk & ~clk_prev;

  always_comb begin
    if (pin.cs_n) begin
      cmd = CMD_DESEL; // R05
    end else begin
      case ({pin.ras_n, pin.cas_n, pin.we_n}) // R04
        RCW_NOP:   cmd = CMD_NOP; // R06
        RCW_ACT:   cmd = CMD_ACT;
        RCW_READ:  cmd = CMD_READ;
        RCW_WRITE: cmd = CMD_WRITE;
        RCW_BST:   cmd = CMD_BST;
        RCW_PRE:   cmd = CMD_PRE;
        RCW_REF:   cmd = CMD_REF;
        RCW_LMR:   cmd = CMD_LMR;
        default:   cmd = CMD_NOP;
      endcase
    end
  end

  assign take = link_edge & pin.cke & ~self_ref;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      operation_mode_register <= MODE_RESET;
    end else if (take && cmd == CMD_LMR && idle == 4'hF) begin
      operation_mode_register <= pin.addr; // R09
    end
  end

  assign bl      = operation_mode_register[BL_LSB +: 3]; // R22
  assign il      = operation_mode_register[BT_BIT];
  assign normal  = !operation_mode_register[OPM_LO_BIT] &&
                   !operation_mode_register[OPM_HI_BIT]; // R01
  assign wsingle = operation_mode_register[WSA_BIT];

  // reserved latency codes fall back to the slowest setting
  always_comb begin
    case (operation_mode_register[RL_LSB +: 3])
      3'h1:    rl_eff = 2'h1;
      3'h2:    rl_eff = 2'h2;
      default: rl_eff = 2'h3;
    endcase
  end

  // test modes stop reads and writes; other commands still act
  assign new_rd = take && cmd == CMD_READ && normal && open[pin.ba];
  assign new_wr = take && cmd == CMD_WRITE && normal && open[pin.ba];
  assign new_rw = new_rd | new_wr;
  assign kill   = take && cmd == CMD_BST;

  always_comb begin
    cur_start = new_rw ? pin.addr[7:0] : start_col; // R12
    cur_idx   = new_rw ? 8'h00 : beat_idx;
    cur_bank  = new_rw ? pin.ba : burst_bank;
    cur_bl    = new_rw ? bl : burst_bl;
    cur_il    = new_rw ? il : burst_il;
    cur_ap    = new_rw ? pin.addr[AP_BIT] : burst_ap; // R19
    if (new_wr && wsingle) begin
      cur_rem = 9'h001; // R02
    end else begin
      cur_rem = new_rw ? sdcm_beats(bl) : rem;
    end
    cur_col = sdcm_col(cur_start, cur_idx, cur_bl, cur_il); // R24
  end

  assign fire_rd = link_edge && ((new_rd && rl_eff == 2'h1) ||
    (!new_rw && !kill && burst_st == BURST_READ && lat_cnt <= 2'h1)); // R23
  assign fire_wr = link_edge &&
    (new_wr || (!new_rw && !kill && burst_st == BURST_WRITE));
  assign last    = (fire_rd || fire_wr) && cur_rem == 9'h001;
  assign ap_pre  = last && cur_ap && cur_bl != BL_PAGE; // R18

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      burst_st   <= BURST_IDLE;
      lat_cnt    <= 2'h0;
      start_col  <= 8'h00;
      beat_idx   <= 8'h00;
      rem        <= 9'h000;
      burst_bank <= 2'h0;
      burst_ap   <= 1'b0;
      burst_bl   <= BL_1;
      burst_il   <= 1'b0;
    end else if (link_edge) begin
      if (new_rw) begin
        start_col  <= pin.addr[7:0];
        burst_bank <= pin.ba;
        burst_ap   <= pin.addr[AP_BIT]; // R12 R19
        burst_bl   <= (new_wr && wsingle) ? BL_1 : bl;
        burst_il   <= il;
        lat_cnt    <= new_rd ? rl_eff - 2'h1 : 2'h0; // R23
      end else if (burst_st == BURST_READ && lat_cnt > 2'h1) begin
        lat_cnt <= lat_cnt - 2'h1;
      end
      if (fire_rd || fire_wr) begin
        beat_idx <= cur_idx + 8'h01;
        rem      <= cur_rem - 9'h001;
      end else if (new_rw) begin
        beat_idx <= 8'h00;
        rem      <= cur_rem;
      end
      case (burst_st)
        BURST_IDLE, BURST_READ, BURST_WRITE: begin
          if (kill || last) begin
            burst_st <= BURST_IDLE;
          end else if (new_rd) begin
            burst_st <= BURST_READ;
          end else if (new_wr) begin
            burst_st <= BURST_WRITE;
          end
        end
        default: burst_st <= BURST_IDLE;
      endcase
    end
  end

  sdcm_banks u_banks (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .act_in      (take && cmd == CMD_ACT),
    .pre_in      (take && cmd == CMD_PRE && !pin.addr[AP_BIT]),
    .pre_all_in  (take && cmd == CMD_PRE && pin.addr[AP_BIT]),
    .bank_in     (pin.ba),
    .row_in      (pin.addr),
    .ap_in       (ap_pre),
    .ap_bank_in  (cur_bank),
    .open_out    (open),
    .idle_out    (idle),
    .row_lsb_out (row_lsb)
  );

  sdcm_store u_store (
    .mclk_in    (mclk_in),
    .wr_in      (fire_wr),
    .lane_we_in (~pin.dqm), // R15
    .index_in   ({cur_bank, row_lsb[cur_bank], cur_col[2:0]}),
    .wdata_in   (pin.dq),
    .rdata_out  (rdata)
  );

  // a beat leaves one link edge before it is due, so the mask taken
  // one edge earlier is the one two clocks ahead of valid data
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dqm_prev  <= 4'hF;
      dq_out    <= 32'h0000_0000;
      dq_oe_out <= 4'h0;
    end else if (link_edge) begin
      dqm_prev <= pin.dqm;
      if (fire_rd) begin
        dq_out    <= rdata;
        dq_oe_out <= ~dqm_prev; // R13 R14
      end else begin
        dq_oe_out <= 4'h0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      refresh_row <= 12'h000;
      self_ref    <= 1'b0;
    end else if (link_edge) begin
      if (take && cmd == CMD_REF) begin
        refresh_row <= refresh_row + 12'h001; // R07 R08
      end
      if (!self_ref && !pin.cke && cmd == CMD_REF) begin
        self_ref <= 1'b1; // R07
      end else if (self_ref && pin.cke) begin
        self_ref <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bank_open_out <= 4'h0;
      test_mode_out <= 1'b0;
    end else begin
      bank_open_out <= open;
      test_mode_out <= !normal;
    end
  end

  assign self_refresh_out = self_ref;
  assign refresh_row_out  = refresh_row;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  desel_hold_a: assert property (link_edge && pin.cs_n |=> // R05
    $stable(operation_mode_register) && $stable(refresh_row))
    else $error("deselected edge changed device state");
  nop_hold_a: assert property (take && cmd == CMD_NOP && !ap_pre |=> // R06
    $stable(operation_mode_register) && $stable(open))
    else $error("no-op changed device state");
  mode_load_a: assert property ( // R09
    take && cmd == CMD_LMR && idle == 4'hF |=>
    operation_mode_register == $past(pin.addr))
    else $error("mode register load lost");
  auto_ref_a: assert property (take && cmd == CMD_REF |=> // R07
    refresh_row == $past(refresh_row) + 12'h001)
    else $error("refresh counter did not advance");
  self_ref_a: assert property ( // R07
    link_edge && !self_ref && !pin.cke && cmd == CMD_REF |=> self_ref)
    else $error("self refresh not entered");
  pre_all_a: assert property ( // R16
    take && cmd == CMD_PRE && pin.addr[AP_BIT] |-> ##2 bank_open_out == 4'h0)
    else $error("precharge all left a bank open");
  act_open_a: assert property ( // R10
    take && cmd == CMD_ACT && idle[pin.ba] |-> ##2
    bank_open_out[$past(pin.ba, 2)])
    else $error("activate did not open bank");
  wr_single_a: assert property (new_wr && wsingle |=> // R02
    burst_st == BURST_IDLE)
    else $error("single write kept bursting");
  rd_mask_a: assert property (fire_rd |=> // R13
    dq_oe_out == ~$past(dqm_prev) && dq_out == $past(rdata))
    else $error("read lane enable does not follow mask");
  rd_lat3_a: assert property (new_rd && rl_eff == 2'h3 |=> // R23
    burst_st == BURST_READ && lat_cnt == 2'h2)
    else $error("latency three read scheduled wrongly");

  rd_cmd_c: cover property (new_rd);
  wr_end_c: cover property (fire_wr && last);
  ap_end_c: cover property (ap_pre);
  self_c:   cover property (self_ref);
endmodule

/* rtl/sdcm_pkg.sv */
package sdcm_pkg;

  localparam int         NBANK       = 4;
  localparam int         ROW_W       = 11;
  localparam int         COL_W       = 8;
  localparam int         REF_W       = 12;
  localparam int         LANES       = 4;
  localparam int         STORE_AW    = 6;

  // operation mode register layout
  localparam logic [10:0] MODE_RESET  = 11'h000;
  localparam int          BL_LSB      = 0;
  localparam int          BT_BIT      = 3;
  localparam int          RL_LSB      = 4;
  localparam int          OPM_LO_BIT  = 7;
  localparam int          OPM_HI_BIT  = 8;
  localparam int          WSA_BIT     = 9;
  localparam int          AP_BIT      = 10;

  localparam logic [2:0] BL_1        = 3'h0;
  localparam logic [2:0] BL_2        = 3'h1;
  localparam logic [2:0] BL_4        = 3'h2;
  localparam logic [2:0] BL_8        = 3'h3;
  localparam logic [2:0] BL_PAGE     = 3'h7;

  // row strobe, column strobe, write enable levels
  localparam logic [2:0] RCW_NOP     = 3'h7;
  localparam logic [2:0] RCW_ACT     = 3'h3;
  localparam logic [2:0] RCW_READ    = 3'h5;
  localparam logic [2:0] RCW_WRITE   = 3'h4;
  localparam logic [2:0] RCW_BST     = 3'h6;
  localparam logic [2:0] RCW_PRE     = 3'h2;
  localparam logic [2:0] RCW_REF     = 3'h1;
  localparam logic [2:0] RCW_LMR     = 3'h0;

  // precharge recovery, a least time, rounded up to whole cycles
  localparam int         MCLK_NS     = 10;
  localparam int         TRP_NS      = 20;
  localparam int         TRP_CYC     = (TRP_NS + MCLK_NS - 1) / MCLK_NS;

  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
    CMD_BST, CMD_PRE, CMD_REF, CMD_LMR
  } sdcm_cmd_e;

  typedef enum logic [1:0] {
    BURST_IDLE, BURST_READ, BURST_WRITE
  } sdcm_burst_e;

  typedef struct packed {
    logic        sd_clk;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [10:0] addr;
    logic [3:0]  dqm;
    logic [31:0] dq;
  } sdcm_pins_s;

  localparam sdcm_pins_s PINS_IDLE = '{sd_clk: 1'b0, cke: 1'b0,
    cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'h0,
    addr: 11'h000, dqm: 4'hF, dq: 32'h0000_0000};

  function automatic logic [8:0] sdcm_beats(input logic [2:0] bl);
    case (bl)
      BL_2:    return 9'h002;
      BL_4:    return 9'h004;
      BL_8:    return 9'h008;
      BL_PAGE: return 9'h100;
      default: return 9'h001;
    endcase
  endfunction

  function automatic logic [7:0] sdcm_col(input logic [7:0] s,
      input logic [7:0] i, input logic [2:0] bl, input logic il);
    logic [7:0] m;
    logic [7:0] lo;
    case (bl)
      BL_2:    m = 8'h01;
      BL_4:    m = 8'h03;
      BL_8:    m = 8'h07;
      BL_PAGE: m = 8'hFF;
      default: m = 8'h00;
    endcase
    lo = (il && bl != BL_PAGE) ? (s ^ i) : 8'(s + i);
    return (s & ~m) | (lo & m);
  endfunction

endpackage

/* rtl/sdcm_store.sv */
module sdcm_store (
  input  wire logic        mclk_in,
  input  wire logic        wr_in,
  input  wire logic [3:0]  lane_we_in,
  input  wire logic [5:0]  index_in,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] rdata_out
);
  import sdcm_pkg::*;

  // small flop arrays; wider addresses alias onto them
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      // one array per lane, so each process is the only writer of its flops
      logic [7:0] mem [2**STORE_AW];
      always_ff @(posedge mclk_in) begin
        if (wr_in && lane_we_in[l]) begin
          mem[index_in] <= wdata_in[8*l +: 8]; // R14 R15
        end
      end
      assign rdata_out[8*l +: 8] = mem[index_in];
    end
  endgenerate
endmodule

/* tb/sdcm_ctrl_model.sv */
module sdcm_ctrl_model (
  input  wire logic             mclk_in,
  output sdcm_pkg::sdcm_pins_s pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdcm_pkg::*;

  // link clock stands low between commands, as a controller may stop it
  initial pins_out = PINS_IDLE;

  // one link cycle of 160 ns: pins settle while the clock is low and stay
  // put across the rise, so sync flops never see a half-changed command
  // 6.25 MHz link rate sits below every latency limit
  task automatic cyc(input logic cs_n, input logic cke,
      input logic [2:0] rcw, input logic [1:0] ba, input logic [10:0] addr,
      input logic [3:0] dqm, input logic [31:0] dq);
    @(posedge mclk_in);
    #1;
    pins_out = '{sd_clk: 1'b0, cke: cke, cs_n: cs_n, ras_n: rcw[2],
      cas_n: rcw[1], we_n: rcw[0], ba: ba, addr: addr, dqm: dqm, dq: dq};
    repeat (7) @(posedge mclk_in);
    #1;
    pins_out.sd_clk = 1'b1;
    repeat (8) @(posedge mclk_in);
    #1;
    pins_out.sd_clk = 1'b0;
  endtask
endmodule

/* tb/tb_top.sv */
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  errors++; $display("wrong value t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdcm_pkg::*;

  logic             mclk_in;
  logic             rst_in;
  sdcm_pins_s       p;
  logic      [31:0] dq_w;
  logic      [31:0] dq_out;
  logic      [3:0]  dq_oe;
  logic             self_ref;
  logic      [11:0] ref_row;
  logic      [3:0]  bank_open;
  logic             test_mode;
  int               errors;
  int               checks_done;
  integer           seed;
  logic      [31:0] mem [64];
  logic      [10:0] row;
  logic      [1:0]  bk;
  logic      [7:0]  col;
  logic      [31:0] d;
  logic      [3:0]  m;
  logic      [3:0]  lm;
  logic      [11:0] rr;
  int               bln [4] = '{1, 2, 8, 4};
  logic      [2:0]  blc [4] = '{BL_1, BL_2, BL_8, BL_4};

  sdcm_ctrl_model u_sdcm_ctrl_model (.mclk_in(mclk_in), .pins_out(p));

  sdcm_core u_sdcm_core (
    .mclk_in(mclk_in), .rst_in(rst_in), .sd_clk_in(p.sd_clk),
    .cke_in(p.cke), .cs_n_in(p.cs_n), .ras_n_in(p.ras_n),
    .cas_n_in(p.cas_n), .we_n_in(p.we_n),
    .bank_select_0_in(p.ba[0]), .bank_select_1_in(p.ba[1]),
    .addr_in(p.addr), .byte_mask_lane0_in(p.dqm[0]),
    .byte_mask_lane1_in(p.dqm[1]), .byte_mask_lane2_in(p.dqm[2]),
    .byte_mask_lane3_in(p.dqm[3]), .dq_in(dq_w), .dq_out(dq_out),
    .dq_oe_out(dq_oe), .self_refresh_out(self_ref),
    .refresh_row_out(ref_row), .bank_open_out(bank_open),
    .test_mode_out(test_mode));

  function automatic logic [31:0] lanes(logic [3:0] k);
    return {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
  endfunction

  // shared data wire: device lanes win where it drives
  assign dq_w = (p.dq & ~lanes(dq_oe)) | (dq_out & lanes(dq_oe));

  function automatic logic [7:0] ecol(logic [7:0] s, int i, int bl,
      logic il);
    logic [7:0] k;
    k = 8'(bl - 1);
    return (s & ~k) | ((il ? s ^ 8'(i) : s + 8'(i)) & k);
  endfunction

  // storage aliases on bank, row bit 0 and low column bits
  function automatic int ix(logic [7:0] c);
    return int'({bk, row[0], c[2:0]});
  endfunction

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic go(logic cs_n, logic cke, logic [2:0] rcw, logic [1:0] ba,
      logic [10:0] a, logic [3:0] dm, logic [31:0] dd);
    lm = p.dqm;
    u_sdcm_ctrl_model.cyc(cs_n, cke, rcw, ba, a, dm, dd);
  endtask

  task automatic cmd(logic [2:0] rcw, logic [10:0] a);
    go(1'b0, 1'b1, rcw, bk, a, 4'($random(seed)), $random(seed));
  endtask

  task automatic wr(int n, int bl, logic il, logic rm);
    for (int i = 0; i < bl; i++) begin
      d = $random(seed);
      m = rm ? 4'($random(seed)) : 4'h0;
      if (i < n)
        mem[ix(ecol(col, i, bl, il))] = (mem[ix(ecol(col, i, bl, il))]
          & lanes(m)) | (d & ~lanes(m));
      go(1'b0, 1'b1, i == 0 ? RCW_WRITE : RCW_NOP, bk,
        i == 0 ? {3'h0, col} : 11'($random(seed)), m, d);
    end
  endtask

  task automatic rd(int lat, int bl, logic il, logic ap);
    for (int e = 0; e <= lat + bl - 1; e++) begin
      cmd(e == 0 ? RCW_READ : RCW_NOP,
        e == 0 ? {ap, 2'h0, col} : 11'($random(seed)));
      if (e >= lat - 1 && e < lat - 1 + bl) begin
        `CHK(dq_oe, ~lm)
        `CHK(dq_out & lanes(~lm),
          mem[ix(ecol(col, e - lat + 1, bl, il))] & lanes(~lm))
      end else begin
        `CHK(dq_oe, 4'h0)
      end
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // about 230 link cycles of 160 ns are expected; allow plenty more
  initial begin
    #200us;
    errors++;
    end_of_test();
  end

  initial begin
    seed = 32'h8714BE52;
    errors = 0;
    checks_done = 0;
    rst_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    `CHK({dq_out, dq_oe, self_ref, ref_row, bank_open, test_mode}, 54'h0)
    for (int lat = 1; lat <= 3; lat++) begin
      for (int k = 0; k < 4; k++) begin
        cmd(RCW_PRE, 11'h400);
        `CHK(bank_open, 4'h0)
        cmd(RCW_LMR, {4'h0, 3'(lat), k[0], blc[k]});
        bk = 2'($random(seed));
        row = 11'($random(seed));
        col = 8'($random(seed));
        cmd(RCW_ACT, row);
        `CHK(bank_open, 4'h1 << bk)
        wr(bln[k], bln[k], k[0], 1'b0);
        wr(bln[k], bln[k], k[0], 1'b1);
        rd(lat, bln[k], k[0], k[1]);
        `CHK(bank_open, k[1] ? 4'h0 : 4'h1 << bk)
      end
    end
    // previous pass filled this aligned block of four
    cmd(RCW_PRE, 11'h400);
    cmd(RCW_LMR, {4'h4, 3'h2, 1'b0, BL_4});
    cmd(RCW_ACT, row);
    wr(1, 4, 1'b0, 1'b0);
    rd(2, 4, 1'b0, 1'b0);
    go(1'b1, 1'b1, RCW_ACT, bk ^ 2'h1, row, 4'h0, $random(seed));
    `CHK(bank_open, 4'h1 << bk)
    go(1'b0, 1'b1, RCW_ACT, bk ^ 2'h1, row, 4'h0, $random(seed));
    cmd(RCW_PRE, {1'b0, row[9:0]});
    `CHK(bank_open, 4'h1 << (bk ^ 2'h1))
    cmd(RCW_PRE, 11'h400);
    cmd(RCW_LMR, {4'h0, 3'h1, 1'b0, BL_PAGE});
    cmd(RCW_ACT, row);
    cmd(RCW_READ, {1'b1, 2'h0, col});
    cmd(RCW_NOP, 11'h000);
    cmd(RCW_BST, 11'h000);
    cmd(RCW_NOP, 11'h000);
    `CHK(dq_oe, 4'h0)
    `CHK(bank_open, 4'h1 << bk)
    cmd(RCW_PRE, 11'h400);
    rr = ref_row + 12'h001;
    cmd(RCW_REF, 11'($random(seed)));
    `CHK(ref_row, rr)
    go(1'b0, 1'b0, RCW_REF, bk, row, 4'h0, $random(seed));
    `CHK(self_ref, 1'b1)
    go(1'b0, 1'b0, RCW_ACT, bk, row, 4'h0, $random(seed));
    `CHK(bank_open, 4'h0)
    cmd(RCW_NOP, row);
    `CHK(self_ref, 1'b0)
    cmd(RCW_ACT, row);
    cmd(RCW_LMR, {4'h1, 3'h2, 1'b0, BL_4});
    `CHK(test_mode, 1'b0)
    cmd(RCW_PRE, 11'h400);
    // test modes loaded on purpose to see them flagged
    for (int o = 3; o >= 0; o--) begin
      cmd(RCW_LMR, {2'h0, 2'(o), 3'h2, 1'b0, BL_4});
      `CHK(test_mode, o != 0)
    end
    end_of_test();
  end
endmodule
